// File: design/csrt_top.sv
// csrt_top: base clock source selection and device reset cascade.
// assumes configuration, software reset and cause-clear writes arrive on clk_i; clocks and the
// power-on, pin and watchdog sources arrive from other domains and are synchronised here.
`timescale 1ns/1ns
`default_nettype none
module csrt_top
   import csrt_pkg::*;
#(
   parameter int unsigned NPLL = DEF_NPLL,
   parameter int unsigned NFDIV = DEF_NFDIV,
   parameter int unsigned NBASE = DEF_NBASE,
   parameter int unsigned STRETCH = RST_STRETCH_CYC,
   parameter int unsigned WIN = DET_WIN_CYC
)
(
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // clock sources: low-power osc, crystal, PLL outputs, dividers
   input wire logic low_power_oscillator_i,
   input wire logic xtal_i,
   input wire logic [NPLL-1:0] pll_clk_i,
   input wire logic [NFDIV-1:0] fractional_divider_clk_i,
   // configuration write
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_tgt_i,
   input wire logic [SEL_W-1:0] cfg_sel_i,
   input wire logic [FLD_W-1:0] cfg_fld_i,
   // clock selection state
   output logic [NFDIV*SEL_W-1:0] fractional_divider_sel_o,
   output logic [NBASE*SEL_W-1:0] base_sel_o,
   output logic [(NFDIV+NBASE+1)*FLD_W-1:0] cfg_fld_o,
   output logic [SEL_W-1:0] pll_ref_sel_o,
   output logic [NFDIV+NBASE-1:0] switch_busy_o,
   output logic sel_rej_o,
   output logic [2+NPLL+NFDIV-1:0] clk_valid_o,
   // reset sources
   input wire logic por_i,
   input wire logic rst_pin_n_i,
   input wire logic wdt_i,
   input wire logic sw_unlock_i,
   input wire logic [15:0] sw_key_i,
   input wire logic sw_rst_wr_i,
   input wire logic cause_clr_i,
   // reset outputs
   output logic por_rst_o,
   output logic unit_rst_o,
   output logic ctrl_rst_o,
   output logic full_cold_reset_o,
   output logic warm_rst_o,
   output logic system_config_reset_o,
   output logic config_id_reset_o,
   output logic sram_controller_reset_o,
   output logic static_memory_reset_o,
   output logic [NUM_WARM_LEAF-1:0] warm_leaf_rst_o,
   output logic core_ahb_rst_o,
   output logic [CAUSE_W-1:0] rst_cause_o
);
   localparam int unsigned NSRC = 2 + NPLL + NFDIV;
   localparam int unsigned NTGT = NFDIV + NBASE;
   localparam int unsigned TGT_PLL = NTGT;

   if (NSRC > (1 << SEL_W) || NBASE < 3 || NPLL < 1 || NTGT > 255) begin : g_chk
      $error("clock layout does not fit the select encoding");
   end

   // ------------------------------------------------------------
   // clock activity
   // ------------------------------------------------------------
   logic [NSRC-1:0] valid;

   csrt_clk_detect #(
      .NCLK(NSRC),
      .WIN(WIN)
   ) u_det (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .clk_src_i({fractional_divider_clk_i, pll_clk_i, xtal_i, low_power_oscillator_i}),
      .clk_valid_o(valid)
   );

   // ------------------------------------------------------------
   // reset cascade
   // ------------------------------------------------------------
   logic [NUM_STAGES-1:0] stg_src, stg;
   logic sw_trig_q, sw_trig_d;

   always_comb
   begin
      stg_src[STG_POR] = por_i;
      stg_src[STG_UNIT] = stg[STG_POR] | ~rst_pin_n_i;
      stg_src[STG_CTRL] = stg[STG_UNIT] | wdt_i;
      stg_src[STG_COLD] = stg[STG_CTRL];
      // software trigger only reaches the peripheral level
      stg_src[STG_WARM] = stg[STG_COLD] | sw_trig_q;
   end

   for (genvar g = 0; g < NUM_STAGES; g++) begin : g_stg
      csrt_rst_stretch #(
         .CNT(STRETCH)
      ) u_str (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .src_i(stg_src[g]),
         .rst_o(stg[g])
      );
   end

   assign por_rst_o = stg[STG_POR];
   assign unit_rst_o = stg[STG_UNIT];
   assign ctrl_rst_o = stg[STG_CTRL];
   assign full_cold_reset_o = stg[STG_COLD];
   assign system_config_reset_o = stg[STG_COLD];
   assign config_id_reset_o = stg[STG_COLD];
   assign sram_controller_reset_o = stg[STG_COLD];
   assign static_memory_reset_o = stg[STG_COLD];
   assign warm_rst_o = stg[STG_WARM];
   assign warm_leaf_rst_o = {NUM_WARM_LEAF{stg[STG_WARM]}};
   assign core_ahb_rst_o = stg[STG_WARM];

   // ------------------------------------------------------------
   // reset cause record and protected software trigger
   // ------------------------------------------------------------
   logic [1:0] pin_sync_q, wdt_sync_q;
   logic armed_q, armed_d;
   logic [CAUSE_W-1:0] cause_q, cause_d, cause_ev;

   always_comb
   begin
      cause_ev = '0;
      cause_ev[CAUSE_POR] = stg[STG_POR];
      cause_ev[CAUSE_PIN] = pin_sync_q[1];
      cause_ev[CAUSE_WDT] = wdt_sync_q[1];
      cause_ev[CAUSE_SW] = sw_trig_q;
      // clear first so a same-cycle event survives
      cause_d = (cause_clr_i ? CAUSE_RST : cause_q) | cause_ev;
      if (stg[STG_POR])
         cause_d = cause_ev; // power-on wipes older history
      armed_d = armed_q;
      sw_trig_d = 1'b0;
      if (sw_unlock_i)
         armed_d = (sw_key_i == RST_KEY);
      else if (sw_rst_wr_i)
      begin
         sw_trig_d = armed_q;
         armed_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i)
   begin
      pin_sync_q <= {pin_sync_q[0], ~rst_pin_n_i};
      wdt_sync_q <= {wdt_sync_q[0], wdt_i};
      if (rst_i)
      begin
         cause_q <= CAUSE_RST;
         armed_q <= 1'b0;
         sw_trig_q <= 1'b0;
      end
      else
      begin
         cause_q <= cause_d;
         armed_q <= armed_d;
         sw_trig_q <= sw_trig_d;
      end
   end

   assign rst_cause_o = cause_q;

   // ------------------------------------------------------------
   // source selection
   // ------------------------------------------------------------
   // targets: dividers first, then base generators, then the PLL
   function automatic logic sel_ok(input int unsigned t, input logic [SEL_W-1:0] s,
                                   input logic [NSRC-1:0] v);
      logic ok;
      ok = (int'(s) < NSRC) && v[s[$clog2(NSRC)-1:0]];
      if (t < NFDIV)
         ok = ok && (int'(s) < 2 + NPLL);
      else if (t == NFDIV + BASE_SAFE || t == NFDIV + BASE_CTRL)
         ok = ok && (s == SRC_LP);
      else if (t >= NTGT)
         ok = 1'b0;
      return ok;
   endfunction : sel_ok

   logic [SEL_W-1:0] cur_q [NTGT], cur_d [NTGT];
   logic [SEL_W-1:0] pend_q [NTGT], pend_d [NTGT];
   logic [NTGT-1:0] busy_q, busy_d;
   logic [FLD_W-1:0] fld_q [NTGT+1], fld_d [NTGT+1];
   logic rej_q, rej_d;
   logic sel_rst;

   // control-domain reset also restarts the selection logic
   assign sel_rst = rst_i | stg[STG_CTRL];

   always_comb
   begin
      rej_d = 1'b0;
      for (int unsigned t = 0; t <= NTGT; t++)
      begin
         fld_d[t] = fld_q[t];
         if (cfg_wr_i && int'(cfg_tgt_i) == t)
            fld_d[t] = cfg_fld_i;
      end
      for (int unsigned t = 0; t < NTGT; t++)
      begin
         cur_d[t] = cur_q[t];
         pend_d[t] = pend_q[t];
         busy_d[t] = busy_q[t];
         // glitch-free hand-over waits for both clocks alive
         if (busy_q[t] && valid[cur_q[t][$clog2(NSRC)-1:0]]
             && valid[pend_q[t][$clog2(NSRC)-1:0]])
         begin
            cur_d[t] = pend_q[t];
            busy_d[t] = 1'b0;
         end
         if (cfg_wr_i && int'(cfg_tgt_i) == t)
         begin
            if (sel_ok(t, cfg_sel_i, valid))
            begin
               pend_d[t] = cfg_sel_i;
               busy_d[t] = (cfg_sel_i != cur_d[t]);
            end
         end
      end
      if (cfg_wr_i && int'(cfg_tgt_i) <= NTGT)
         rej_d = !sel_ok(int'(cfg_tgt_i), cfg_sel_i, valid);
   end

   always_ff @(posedge clk_i)
   begin
      if (sel_rst)
      begin
         for (int unsigned t = 0; t < NTGT; t++)
         begin
            cur_q[t] <= SRC_LP;
            pend_q[t] <= SRC_LP;
         end
         for (int unsigned t = 0; t <= NTGT; t++)
            fld_q[t] <= FLD_RST;
         busy_q <= '0;
         rej_q <= 1'b0;
      end
      else
      begin
         cur_q <= cur_d;
         pend_q <= pend_d;
         fld_q <= fld_d;
         busy_q <= busy_d;
         rej_q <= rej_d;
      end
   end

   for (genvar g = 0; g < NTGT; g++) begin : g_out
      if (g < NFDIV) begin : g_fd
         assign fractional_divider_sel_o[g*SEL_W +: SEL_W] = cur_q[g];
      end
      else begin : g_bs
         assign base_sel_o[(g-NFDIV)*SEL_W +: SEL_W] = cur_q[g];
      end
   end
   for (genvar g = 0; g <= NTGT; g++) begin : g_fld
      assign cfg_fld_o[g*FLD_W +: FLD_W] = fld_q[g];
   end

   logic [SEL_W-1:0] pll_ref_q;
   always_ff @(posedge clk_i)
   begin
      pll_ref_q <= SRC_XTAL;
   end

   assign pll_ref_sel_o = pll_ref_q;
   assign switch_busy_o = busy_q;
   assign sel_rej_o = rej_q;
   assign clk_valid_o = valid;

endmodule : csrt_top
`default_nettype wire

// File: design/csrt_pkg.sv
// csrt_pkg: constants shared by the clock source and reset tree block.
// assumes a single 100 MHz system clock; all counts derive from it.
package csrt_pkg;

   // ------------------------------------------------------------
   // clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned DET_WIN_NS = 640;
   localparam int unsigned DET_WIN_CYC = DET_WIN_NS / CLK_PERIOD_NS;
   localparam int unsigned RST_STRETCH_NS = 160;
   localparam int unsigned RST_STRETCH_CYC = RST_STRETCH_NS / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // source and target layout
   // ------------------------------------------------------------
   localparam int unsigned SEL_W = 5;
   localparam int unsigned FLD_W = 8;
   localparam int unsigned DEF_NPLL = 3;
   localparam int unsigned DEF_NFDIV = 7;
   localparam int unsigned DEF_NBASE = 8;
   localparam logic [SEL_W-1:0] SRC_LP = 5'h00;
   localparam logic [SEL_W-1:0] SRC_XTAL = 5'h01;
   localparam logic [SEL_W-1:0] SRC_PLL0 = 5'h02;
   localparam int unsigned BASE_SAFE = 0;
   localparam int unsigned BASE_CTRL = 1;
   localparam int unsigned BASE_SYS = 2;
   localparam logic [FLD_W-1:0] FLD_RST = 8'h00;

   // ------------------------------------------------------------
   // reset cascade
   // ------------------------------------------------------------
   localparam int unsigned NUM_STAGES = 5;
   localparam int unsigned STG_POR = 0;
   localparam int unsigned STG_UNIT = 1;
   localparam int unsigned STG_CTRL = 2;
   localparam int unsigned STG_COLD = 3;
   localparam int unsigned STG_WARM = 4;
   localparam int unsigned NUM_WARM_LEAF = 18;
   localparam logic [15:0] RST_KEY = 16'hA5C3;
   localparam int unsigned CAUSE_W = 4;
   localparam int unsigned CAUSE_POR = 0;
   localparam int unsigned CAUSE_PIN = 1;
   localparam int unsigned CAUSE_WDT = 2;
   localparam int unsigned CAUSE_SW = 3;
   localparam logic [CAUSE_W-1:0] CAUSE_RST = 4'h0;

endpackage : csrt_pkg

// File: design/csrt_clk_detect.sv
// csrt_clk_detect: per-clock activity detector.
// assumes each watched clock runs below half the system clock rate.
`timescale 1ns/1ns
`default_nettype none
module csrt_clk_detect
   import csrt_pkg::*;
#(
   parameter int unsigned NCLK = 12,
   parameter int unsigned WIN = DET_WIN_CYC
)
(
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // watched clocks
   input wire logic [NCLK-1:0] clk_src_i,
   // result
   output logic [NCLK-1:0] clk_valid_o
);
   localparam int unsigned WW = $clog2(WIN + 1);

   if (WIN < 2) begin : g_chk
      $error("detector window too short");
   end

   logic [NCLK-1:0] s1_q, s2_q, s3_q, seen_q, seen_d, valid_q, valid_d;
   logic [WW-1:0] win_q, win_d;
   logic win_end;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      win_end = (win_q == '0);
      win_d = win_end ? WW'(WIN - 1) : win_q - 1'b1;
      valid_d = valid_q;
      seen_d = seen_q | (s2_q ^ s3_q);
      // a clock that never toggled in a whole window is invalid
      if (win_end)
      begin
         valid_d = seen_d;
         seen_d = '0;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      s1_q <= clk_src_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (rst_i)
      begin
         win_q <= WW'(WIN - 1);
         seen_q <= '0;
         valid_q <= '0;
      end
      else
      begin
         win_q <= win_d;
         seen_q <= seen_d;
         valid_q <= valid_d;
      end
   end

   assign clk_valid_o = valid_q;

endmodule : csrt_clk_detect
`default_nettype wire

// File: design/csrt_rst_stretch.sv
// csrt_rst_stretch: one reset stage, asserted at once, released late.
// assumes src_i may change at any time relative to clk_i.
`timescale 1ns/1ns
`default_nettype none
module csrt_rst_stretch
   import csrt_pkg::*;
#(
   parameter int unsigned CNT = RST_STRETCH_CYC
)
(
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // reset request, any domain
   input wire logic src_i,
   // stretched reset
   output logic rst_o
);
   localparam int unsigned CW = $clog2(CNT + 1);

   if (CNT < 1) begin : g_chk
      $error("stretch count must be at least one");
   end

   logic [1:0] sync_q, sync_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic hold_q, hold_d;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      sync_d = {sync_q[0], 1'b0};
      cnt_d = cnt_q;
      hold_d = 1'b1;
      if (sync_q[1])
         cnt_d = CW'(CNT);
      else if (cnt_q != '0)
         cnt_d = cnt_q - 1'b1;
      else
         hold_d = 1'b0;
   end

   // ------------------------------------------------------------
   // registers: preset at once, release through the synchroniser
   // ------------------------------------------------------------
   always_ff @(posedge clk_i or posedge src_i)
   begin
      if (src_i)
      begin
         sync_q <= 2'h3;
         cnt_q <= CW'(CNT);
         hold_q <= 1'b1;
      end
      else if (rst_i)
      begin
         sync_q <= 2'h3;
         cnt_q <= CW'(CNT);
         hold_q <= 1'b1;
      end
      else
      begin
         sync_q <= sync_d;
         cnt_q <= cnt_d;
         hold_q <= hold_d;
      end
   end

   assign rst_o = hold_q;

endmodule : csrt_rst_stretch
`default_nettype wire

// File: testbench/csrt_top_props.sv
// csrt_top_props: concurrent checks on the reset cascade and selection.
// assumes it is bound to csrt_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module csrt_top_props
   import csrt_pkg::*;
#(
   parameter int unsigned NFDIV = DEF_NFDIV,
   parameter int unsigned NBASE = DEF_NBASE,
   parameter int unsigned STRETCH = RST_STRETCH_CYC
)
(
   // system
   input wire logic clk_i,
   input wire logic rst_i,
   // stimulus
   input wire logic por_i,
   input wire logic rst_pin_n_i,
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_tgt_i,
   input wire logic [SEL_W-1:0] cfg_sel_i,
   // selection state
   input wire logic [NFDIV*SEL_W-1:0] fractional_divider_sel_o,
   input wire logic [NBASE*SEL_W-1:0] base_sel_o,
   input wire logic [SEL_W-1:0] pll_ref_sel_o,
   input wire logic sel_rej_o,
   // reset outputs
   input wire logic por_rst_o,
   input wire logic unit_rst_o,
   input wire logic ctrl_rst_o,
   input wire logic full_cold_reset_o,
   input wire logic warm_rst_o,
   input wire logic system_config_reset_o,
   input wire logic config_id_reset_o,
   input wire logic sram_controller_reset_o,
   input wire logic static_memory_reset_o,
   input wire logic [NUM_WARM_LEAF-1:0] warm_leaf_rst_o,
   input wire logic core_ahb_rst_o
);
   // slack covers the two sync edges plus sampling skew
   localparam int REL_MAX = STRETCH + 6;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ------------------------------------------------------------
   // reset cascade
   // ------------------------------------------------------------
   chk_por_unit:
      assert property (por_rst_o |-> unit_rst_o) else $error("unit reset low under por");
   chk_unit_ctrl:
      assert property (unit_rst_o |-> ctrl_rst_o) else $error("ctrl reset low under unit");
   chk_ctrl_cold:
      assert property (ctrl_rst_o |-> full_cold_reset_o) else $error("cold reset low under ctrl");
   chk_cold_warm:
      assert property (full_cold_reset_o |-> warm_rst_o) else $error("warm reset low under cold");
   chk_cold_leaves:
      assert property ({system_config_reset_o, config_id_reset_o, sram_controller_reset_o,
         static_memory_reset_o} == {4{full_cold_reset_o}}) else $error("cold leaf differs");
   chk_warm_leaves:
      assert property ({core_ahb_rst_o, warm_leaf_rst_o} == {(NUM_WARM_LEAF+1){warm_rst_o}})
         else $error("warm leaf differs");
   chk_pin_unit:
      assert property ($fell(rst_pin_n_i) |-> ##[0:3] unit_rst_o) else $error("pin ignored");
   chk_por_stretch:
      assert property (por_i |=> por_rst_o [*3]) else $error("por reset released early");
   chk_por_release:
      assert property ($fell(por_i) |-> ##[1:REL_MAX] !por_rst_o) else $error("por stuck");
   // ------------------------------------------------------------
   // source selection
   // ------------------------------------------------------------
   chk_safe_lp:
      assert property (base_sel_o[BASE_SAFE*SEL_W +: SEL_W] == SRC_LP
         && base_sel_o[BASE_CTRL*SEL_W +: SEL_W] == SRC_LP) else $error("safe clock moved");
   chk_rst_default:
      assert property ($fell(rst_i) |-> base_sel_o == '0 && fractional_divider_sel_o == '0)
         else $error("selection not low-power after reset");
   chk_ctrl_default:
      assert property ($fell(ctrl_rst_o) |-> base_sel_o == '0 && fractional_divider_sel_o == '0)
         else $error("selection not low-power after control reset");
   chk_ref_fixed:
      assert property (!$past(rst_i) |-> pll_ref_sel_o == SRC_XTAL) else $error("ref moved");
   chk_safe_rej:
      assert property (cfg_wr_i && !ctrl_rst_o && cfg_tgt_i == NFDIV + BASE_SAFE
         && cfg_sel_i != SRC_LP |=> sel_rej_o) else $error("safe selection not refused");
endmodule : csrt_top_props

bind csrt_top csrt_top_props #(.NFDIV(NFDIV), .NBASE(NBASE), .STRETCH(STRETCH))
   csrt_top_props_inst (.clk_i, .rst_i, .por_i, .rst_pin_n_i, .cfg_wr_i, .cfg_tgt_i,
   .cfg_sel_i, .fractional_divider_sel_o, .base_sel_o, .pll_ref_sel_o, .sel_rej_o, .por_rst_o,
   .unit_rst_o, .ctrl_rst_o, .full_cold_reset_o, .warm_rst_o, .system_config_reset_o,
   .config_id_reset_o, .sram_controller_reset_o, .static_memory_reset_o,
   .warm_leaf_rst_o, .core_ahb_rst_o);
`default_nettype wire

// File: testbench/csrt_top_tb_top.sv
// csrt_top_tb_top: self-checking bench for the clock source and reset tree.
// assumes csrt_top with a short stretch and detector window for speed.
`timescale 1ns/1ns
`default_nettype none
module csrt_top_tb_top;
   import csrt_pkg::*;
   typedef struct {logic rej; logic busy; int tgt; logic [7:0] fld;} csrt_note_s;
   // pll output 2 is left dead so its selection must be refused
   localparam logic [11:0] RUN = 12'hFEF;
   localparam int TG[12] = '{9, 10, 11, 12, 0, 1, 7, 8, 2, 15, 13, 14};
   localparam int SL[12] = '{1, 2, 2, 5, 3, 1, 1, 2, 6, 0, 4, 31};
   localparam logic [4:0] STG_X[4] = '{5'h0F, 5'h07, 5'h01, 5'h1F};
   // the bench reset holds the power-on stage, so the record starts with that bit
   localparam logic [3:0] CAUSE_X[4] = '{4'h3, 4'h7, 4'hF, 4'h1};
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic low_power_oscillator_i = 1'b0, xtal_i = 1'b0, ph = 1'b0, pend = 1'b0;
   logic [2:0] pll_clk_i = '0;
   logic [6:0] fractional_divider_clk_i = '0;
   logic cfg_wr_i = 1'b0;
   logic [7:0] cfg_tgt_i = '0, cfg_fld_i = '0;
   logic [4:0] cfg_sel_i = '0, pll_ref_sel_o;
   logic por_i = 1'b0, rst_pin_n_i = 1'b1, wdt_i = 1'b0, sw_unlock_i = 1'b0;
   logic sw_rst_wr_i = 1'b0, cause_clr_i = 1'b0;
   logic [15:0] sw_key_i = '0;
   logic [34:0] fractional_divider_sel_o;
   logic [39:0] base_sel_o;
   logic [127:0] cfg_fld_o;
   logic [14:0] switch_busy_o;
   logic [11:0] clk_valid_o;
   logic sel_rej_o, por_rst_o, unit_rst_o, ctrl_rst_o, full_cold_reset_o, warm_rst_o;
   logic system_config_reset_o, config_id_reset_o, sram_controller_reset_o;
   logic static_memory_reset_o, core_ahb_rst_o;
   logic [17:0] warm_leaf_rst_o;
   logic [3:0] rst_cause_o;
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;
   int seed = 64;
   csrt_note_s q[$];
   csrt_note_s n;

   csrt_top #(.STRETCH(2), .WIN(8)) csrt_top_inst (.clk_i, .rst_i, .low_power_oscillator_i, .xtal_i,
      .pll_clk_i, .fractional_divider_clk_i, .cfg_wr_i, .cfg_tgt_i, .cfg_sel_i, .cfg_fld_i, .fractional_divider_sel_o,
      .base_sel_o, .cfg_fld_o, .pll_ref_sel_o, .switch_busy_o, .sel_rej_o, .clk_valid_o,
      .por_i, .rst_pin_n_i, .wdt_i, .sw_unlock_i, .sw_key_i, .sw_rst_wr_i, .cause_clr_i,
      .por_rst_o, .unit_rst_o, .ctrl_rst_o, .full_cold_reset_o, .warm_rst_o, .system_config_reset_o,
      .config_id_reset_o, .sram_controller_reset_o, .static_memory_reset_o,
      .warm_leaf_rst_o, .core_ahb_rst_o, .rst_cause_o);

   // ------------------------------------------------------------
   // clocks, watched sources and result monitor
   // ------------------------------------------------------------
   initial forever #5 clk_i = ~clk_i;

   // watched clocks at 25 MHz, below the detector's limit
   always @(posedge clk_i)
   begin
      ph <= ~ph;
      if (ph)
      begin
         low_power_oscillator_i <= ~low_power_oscillator_i;
         xtal_i <= ~xtal_i;
         pll_clk_i <= pll_clk_i ^ RUN[4:2];
         fractional_divider_clk_i <= fractional_divider_clk_i ^ RUN[11:5];
      end
   end

   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc > 20000)
      begin
         fail_count++;
         wrap_up();
      end
      else
      begin
         if (pend)
         begin
            n = q.pop_front();
            chk(sel_rej_o, n.rej);
            chk(cfg_fld_o[n.tgt*8 +: 8], n.fld);
            chk(n.tgt < 15 ? switch_busy_o[n.tgt] : 1'b0, n.busy);
         end
         pend <= cfg_wr_i;
      end
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [39:0] act, input logic [39:0] exp);
      total_checks++;
      if (act !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, act, exp);
      end
   endtask : chk

   task automatic settle();
      int k;
      k = 0;
      while ((warm_rst_o !== 1'b0 || switch_busy_o !== '0) && k < 200)
      begin
         @(posedge clk_i);
         k++;
      end
      chk({warm_rst_o, switch_busy_o}, '0);
   endtask : settle

   task automatic cfg_write(input int tgt, input int sel, input logic rej);
      csrt_note_s m;
      @(posedge clk_i);
      m.rej = rej;
      // every legally written target still sits on the low-power source, so a legal pick must switch
      m.busy = !rej;
      m.tgt = tgt;
      m.fld = 8'($random(seed));
      q.push_back(m);
      cfg_wr_i <= 1'b1;
      cfg_tgt_i <= 8'(tgt);
      cfg_sel_i <= 5'(sel);
      cfg_fld_i <= m.fld;
      @(posedge clk_i);
      cfg_wr_i <= 1'b0;
      @(posedge clk_i);
      settle();
   endtask : cfg_write

   function automatic logic [4:0] cur_sel(input int tgt);
      if (tgt < 7)
         return fractional_divider_sel_o[tgt*5 +: 5];
      if (tgt < 15)
         return base_sel_o[(tgt-7)*5 +: 5];
      return pll_ref_sel_o;
   endfunction : cur_sel

   task automatic wrap_up();
      if (fail_count == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : wrap_up

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      repeat (30) @(posedge clk_i);
      chk(clk_valid_o, RUN);
      chk(fractional_divider_sel_o, '0);
      chk(base_sel_o, '0);
      chk(pll_ref_sel_o, SRC_XTAL);
      chk(rst_cause_o, 4'h1);
      // first six are legal, the rest must keep the old source
      for (int i = 0; i < 12; i++)
      begin
         cfg_write(TG[i], SL[i], i > 5);
         chk(cur_sel(TG[i]), i > 5 ? (TG[i] == 15) : SL[i]);
      end
      // pin, watchdog, software, power-on
      for (int s = 0; s < 4; s++)
      begin
         @(posedge clk_i);
         if (s == 2)
         begin
            sw_unlock_i <= 1'b1;
            sw_key_i <= ~RST_KEY;
            @(posedge clk_i);
            sw_unlock_i <= 1'b0;
            sw_rst_wr_i <= 1'b1;
            @(posedge clk_i);
            sw_rst_wr_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            chk(warm_rst_o, 1'b0);
            sw_unlock_i <= 1'b1;
            sw_key_i <= RST_KEY;
            @(posedge clk_i);
            sw_unlock_i <= 1'b0;
            sw_rst_wr_i <= 1'b1;
            @(posedge clk_i);
            sw_rst_wr_i <= 1'b0;
         end
         rst_pin_n_i <= (s != 0);
         wdt_i <= (s == 1);
         por_i <= (s == 3);
         repeat (3) @(posedge clk_i);
         chk({por_rst_o, unit_rst_o, ctrl_rst_o, full_cold_reset_o, warm_rst_o}, STG_X[s]);
         chk({system_config_reset_o, config_id_reset_o, sram_controller_reset_o,
            static_memory_reset_o}, {4{STG_X[s][1]}});
         chk({core_ahb_rst_o, warm_leaf_rst_o}, {19{STG_X[s][0]}});
         rst_pin_n_i <= 1'b1;
         wdt_i <= 1'b0;
         por_i <= 1'b0;
         @(posedge clk_i);
         settle();
         chk(rst_cause_o, CAUSE_X[s]);
         chk(base_sel_o, '0);
      end
      // clear the record while no source is active
      @(posedge clk_i);
      cause_clr_i <= 1'b1;
      @(posedge clk_i);
      cause_clr_i <= 1'b0;
      @(posedge clk_i);
      chk(rst_cause_o, CAUSE_RST);
      wrap_up();
   end
endmodule : csrt_top_tb_top
`default_nettype wire
